//--- i2csw_pkg.sv
// ****************************************************************
// Shared constants of the switch slave and its bus master
// ****************************************************************
package i2csw_pkg;

  // Clock rates and link timing
  localparam int SYS_CLK_NS    = 40;                                   // System clock period
  localparam int LINK_CLK_NS   = 160;                                  // Device sampling clock period
  localparam int SCL_PERIOD_NS = 10000;                                // Target 100 kHz bus clock
  localparam int SCL_QTR_CYC   = SCL_PERIOD_NS / (4 * SYS_CLK_NS);     // Quarter bit, rounded down
  localparam int BUS_FREE_NS   = 4700;                                 // Idle time seen before a START
  localparam int BUS_FREE_CYC  = (BUS_FREE_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
  localparam int RST_PULSE_NS  = 500;                                  // Least external reset pulse
  localparam int RST_PULSE_CYC = (RST_PULSE_NS + LINK_CLK_NS - 1) / LINK_CLK_NS;
  localparam int FILT_LEN      = 3;                                    // Glitch filter depth

  // Addressing and control byte layout
  localparam int       ADDR_W     = 7;
  localparam int       CHAN_CNT   = 4;
  localparam logic [3:0] ADDR_HI  = 4'hE;                              // Fixed upper address bits
  localparam int       RW_BIT     = 0;                                 // Direction bit of address byte
  localparam logic [7:0] CTRL_RST = 8'h00;                             // Control byte after reset
  localparam int       ACK_SLOT   = 8;                                 // Bit index of acknowledge slot

endpackage : i2csw_pkg

//--- i2csw_link_if.sv
`timescale 1ns/1ns
// ****************************************************************
// Two-wire link between master and switch slave
// ****************************************************************
interface i2csw_link_if;
  logic m_scl_o;   // Master clock drive level
  logic m_scl_oe;  // Master pulls clock line
  logic m_sda_o;   // Master data drive level
  logic m_sda_oe;  // Master pulls data line
  logic d_sda_o;   // Slave data drive level
  logic d_sda_oe;  // Slave pulls data line
  logic scl;       // Resolved clock line
  logic sda;       // Resolved data line

  // Open-drain wired AND, pull-ups make the idle level high
  assign scl = ~(m_scl_oe & ~m_scl_o);
  assign sda = ~((m_sda_oe & ~m_sda_o) | (d_sda_oe & ~d_sda_o));

  modport master (output m_scl_o, m_scl_oe, m_sda_o, m_sda_oe, input scl, sda);
  modport dev    (output d_sda_o, d_sda_oe, input scl, sda);
endinterface : i2csw_link_if

//--- i2csw_dev.sv
`timescale 1ns/1ns
// What this block does
// - Long enough low reset pin resets everything
// - Hold reset until supply is good
// - Reset leaves control zero, no channel
// - One bit per clock, data steady high
// - Idle bus: nobody pulls either line
// - Master starts only on idle bus
// - Data falling with clock high: START
// - Data rising with clock high: STOP
// - Unlimited bytes between START and STOP
// - Ninth slot, transmitter releases data
// - Master gives ninth clock per byte
// - Addressed receiver acknowledges every byte
// - Acknowledger holds data low whole high
// - Master reader acknowledges all but last
// - Master ends read with no acknowledge
// - Unacknowledged transmitter releases data line
// - Write loads the channel select byte
// - Read returns the channel select byte
// - Address last bit: one read, zero write
// - Several written bytes: last one kept
// - Low four bits each enable one channel
// - New selection applies after STOP
module i2csw_dev
  import i2csw_pkg::*;
#(
  parameter int FILT    = FILT_LEN,       // Filter depth in link clocks
  parameter int RST_CYC = RST_PULSE_CYC   // Least reset pin low time in link clocks
) (
  input  wire logic                link_clk,     // Sampling clock of the slave
  input  wire logic                rst,          // Synchronous reset, active high
  input  wire logic                reset_n,      // External reset pin, active low
  input  wire logic                supply_ok,    // Supply above power-on threshold
  input  wire logic [2:0]          addr_sel,     // Address strap pins
  i2csw_link_if.dev                link,         // Upstream two-wire bus
  output logic [CHAN_CNT-1:0]      channel_en    // Active downstream channel pairs
);

  // ****************************************************************
  // Types and declarations
  // ****************************************************************
  typedef enum logic [2:0] {
    S_IDLE, S_ADDR, S_ADDR_ACK, S_WR, S_WR_ACK, S_RD, S_RD_ACK, S_IGNORE
  } i2csw_dev_e;

  localparam logic [6:0] SYNC_RST = 7'b000_1011;  // {addr, reset_n, supply, scl, sda}

  i2csw_dev_e       state;
  logic [6:0]       sync_a;
  logic [6:0]       sync_b;
  logic [FILT-1:0]  scl_hist;
  logic [FILT-1:0]  sda_hist;
  logic             scl_f;
  logic             sda_f;
  logic             scl_d;
  logic             sda_d;
  logic [7:0]       rst_cnt;
  logic [7:0]       shift;
  logic [7:0]       ctrl;
  logic [3:0]       cnt;
  logic             pending;
  logic             master_ack;
  logic             sda_oe;

  // ****************************************************************
  // Filter helper
  // ****************************************************************
  // Output moves only when the whole history agrees
  function automatic logic filt_next(input logic [FILT-1:0] hist, input logic cur);
    if (&hist) begin
      filt_next = 1'b1;
    end else if (~|hist) begin
      filt_next = 1'b0;
    end else begin
      filt_next = cur;
    end
  endfunction : filt_next

  // ****************************************************************
  // Pin synchronisers and reset sources
  // ****************************************************************
  // Two flops on every pin; the first one feeds nothing else
  always_ff @(posedge link_clk) begin
    if (rst) begin
      sync_a <= SYNC_RST;
      sync_b <= SYNC_RST;
    end else begin
      sync_a <= {addr_sel, reset_n, supply_ok, link.scl, link.sda};
      sync_b <= sync_a;
    end
  end

  wire       scl_s    = sync_b[1];
  wire       sda_s    = sync_b[0];
  wire       supply_s = sync_b[2];
  wire       rpin_s   = sync_b[3];
  wire [2:0] addr_s   = sync_b[6:4];

  // Pin must stay low for the full count, short dips are ignored
  always_ff @(posedge link_clk) begin
    if (rst || rpin_s) begin
      rst_cnt <= 8'h00;
    end else if (rst_cnt != 8'(RST_CYC)) begin
      rst_cnt <= rst_cnt + 8'h01;
    end
  end

  wire pin_rst  = (rst_cnt == 8'(RST_CYC));
  wire por_hold = ~supply_s;
  wire chip_rst = rst | pin_rst | por_hold;

  // ****************************************************************
  // Glitch filter and bus condition detection
  // ****************************************************************
  // Filter adds FILT+1 link clocks of delay but hides short spikes
  always_ff @(posedge link_clk) begin
    if (rst) begin
      scl_hist <= '1;
      sda_hist <= '1;
      scl_f    <= 1'b1;
      sda_f    <= 1'b1;
      scl_d    <= 1'b1;
      sda_d    <= 1'b1;
    end else begin
      scl_hist <= {scl_hist[FILT-2:0], scl_s};
      sda_hist <= {sda_hist[FILT-2:0], sda_s};
      scl_f    <= filt_next(scl_hist, scl_f);
      sda_f    <= filt_next(sda_hist, sda_f);
      scl_d    <= scl_f;
      sda_d    <= sda_f;
    end
  end

  // Data changes under a high clock are conditions, not bits
  wire scl_rise  = scl_f & ~scl_d;
  wire scl_fall  = ~scl_f & scl_d;
  wire start_det = scl_f & scl_d & sda_d & ~sda_f;
  wire stop_det  = scl_f & scl_d & ~sda_d & sda_f;
  wire addr_hit  = (shift[7:1] == {ADDR_HI, addr_s});
  wire byte_end  = scl_fall && (cnt == 4'(ACK_SLOT));
  wire [2:0] rd_sel = 3'd7 - cnt[2:0];

  // ****************************************************************
  // Serial state machine
  // ****************************************************************
  // Bits are sampled on the filtered rise and driven after the fall
  always_ff @(posedge link_clk) begin
    if (chip_rst) begin
      state   <= S_IDLE;
      shift   <= 8'h00;
      cnt     <= 4'h0;
      sda_oe  <= 1'b0;
      pending <= 1'b0;
      ctrl    <= CTRL_RST;
      master_ack <= 1'b0;
    end else if (start_det) begin
      state  <= S_ADDR;
      cnt    <= 4'h0;
      sda_oe <= 1'b0;
    end else if (stop_det) begin
      state   <= S_IDLE;
      sda_oe  <= 1'b0;
      pending <= 1'b0;
    end else begin
      unique case (state)
        S_IDLE, S_IGNORE: begin
          sda_oe <= 1'b0;
        end
        S_ADDR: begin
          if (scl_rise) begin
            shift <= {shift[6:0], sda_f};
            cnt   <= cnt + 4'h1;
          end else if (byte_end) begin
            state  <= addr_hit ? S_ADDR_ACK : S_IGNORE;
            sda_oe <= addr_hit;
          end
        end
        S_ADDR_ACK: begin
          if (scl_fall) begin
            cnt <= 4'h0;
            if (shift[RW_BIT]) begin
              state  <= S_RD;
              sda_oe <= ~ctrl[7];
            end else begin
              state  <= S_WR;
              sda_oe <= 1'b0;
            end
          end
        end
        S_WR: begin
          if (scl_rise) begin
            shift <= {shift[6:0], sda_f};
            cnt   <= cnt + 4'h1;
          end else if (byte_end) begin
            state   <= S_WR_ACK;
            sda_oe  <= 1'b1;
            ctrl    <= shift;
            pending <= 1'b1;
          end
        end
        S_WR_ACK: begin
          if (scl_fall) begin
            state  <= S_WR;
            cnt    <= 4'h0;
            sda_oe <= 1'b0;
          end
        end
        S_RD: begin
          if (scl_rise) begin
            cnt <= cnt + 4'h1;
          end else if (byte_end) begin
            state  <= S_RD_ACK;
            sda_oe <= 1'b0;
          end else if (scl_fall) begin
            sda_oe <= ~ctrl[rd_sel];
          end
        end
        S_RD_ACK: begin
          if (scl_rise) begin
            master_ack <= ~sda_f;
          end else if (scl_fall) begin
            cnt <= 4'h0;
            if (master_ack) begin
              state  <= S_RD;
              sda_oe <= ~ctrl[7];
            end else begin
              state  <= S_IGNORE;
              sda_oe <= 1'b0;
            end
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // Channel enables and pin drive
  // ****************************************************************
  // Switching waits for STOP so all downstream lines are high at connect
  always_ff @(posedge link_clk) begin
    if (chip_rst) begin
      channel_en <= CTRL_RST[CHAN_CNT-1:0];
    end else if (stop_det && pending) begin
      channel_en <= ctrl[CHAN_CNT-1:0];
    end
  end

  // Open drain: only ever pulls low
  assign link.d_sda_o  = 1'b0;
  assign link.d_sda_oe = sda_oe;

endmodule : i2csw_dev

//--- i2csw_master.sv
`timescale 1ns/1ns
// ****************************************************************
// Bus master that drives the switch slave
// ****************************************************************
module i2csw_master
  import i2csw_pkg::*;
#(
  parameter int QTR  = SCL_QTR_CYC,   // System clocks per quarter bit
  parameter int FREE = BUS_FREE_CYC   // Idle clocks needed before START
) (
  input  wire logic              clk,        // System clock
  input  wire logic              rst,        // Synchronous reset, active high
  i2csw_link_if.master           link,       // Two-wire bus
  input  wire logic              cmd_valid,  // Start a transaction
  input  wire logic              cmd_read,   // One for read, zero for write
  input  wire logic [ADDR_W-1:0] cmd_addr,   // Target address
  input  wire logic [3:0]        cmd_len,    // Data bytes, zero counts as one
  input  wire logic [7:0]        cmd_wdata,  // Byte sent for every write byte
  output logic                   busy,       // Transaction in progress
  output logic                   done,       // Pulse at end of STOP
  output logic                   nack,       // Last transaction saw a NACK
  output logic                   rd_valid,   // Pulse with each read byte
  output logic [7:0]             rd_data     // Last byte read
);

  typedef enum logic [2:0] {M_IDLE, M_WAIT, M_START, M_BIT, M_STOP} i2csw_mst_e;

  i2csw_mst_e  state;
  logic [15:0] tmr;
  logic [15:0] idle_cnt;
  logic [1:0]  ph;
  logic [3:0]  bit_idx;
  logic [3:0]  left;
  logic        first;
  logic        rd_mode;
  logic [7:0]  tx;
  logic [7:0]  rx;
  logic        scl_oe;
  logic        sda_oe;
  logic [1:0]  scl_sync;
  logic [1:0]  sda_sync;

  // ****************************************************************
  // Line synchronisers and step decode
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      scl_sync <= 2'b11;
      sda_sync <= 2'b11;
    end else begin
      scl_sync <= {scl_sync[0], link.scl};
      sda_sync <= {sda_sync[0], link.sda};
    end
  end

  wire step      = (tmr == 16'(QTR - 1));
  wire in_ack    = (bit_idx == 4'(ACK_SLOT));
  wire reading   = rd_mode & ~first;
  wire last      = (left == 4'h1);
  wire tx_low    = ~tx[3'd7 - bit_idx[2:0]];
  // Ack slot: receiver acks all but the last byte, transmitter releases; reader releases data bits
  wire drive_low = in_ack ? (reading & ~last) : (~reading & tx_low);
  wire bus_idle  = scl_sync[1] & sda_sync[1];
  wire ack_seen  = ~sda_sync[1];

  // Data bits change only while the clock is held low; START and STOP move data with the clock high
  wire next_scl_oe = (state == M_BIT || state == M_STOP) && (ph < 2'd2);
  wire next_sda_oe = (state == M_START) ? 1'b1 :
                     (state == M_BIT)   ? ((ph == 2'd0) ? sda_oe : drive_low) :
                     (state == M_STOP)  ? ((ph == 2'd0) ? sda_oe : (ph != 2'd3)) :
                     1'b0;

  // ****************************************************************
  // Transaction sequencer
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      state    <= M_IDLE;
      tmr      <= 16'h0000;
      idle_cnt <= 16'h0000;
      ph       <= 2'd0;
      bit_idx  <= 4'h0;
      left     <= 4'h0;
      first    <= 1'b0;
      rd_mode  <= 1'b0;
      tx       <= 8'h00;
      rx       <= 8'h00;
      busy     <= 1'b0;
      done     <= 1'b0;
      nack     <= 1'b0;
      rd_valid <= 1'b0;
      rd_data  <= 8'h00;
    end else begin
      done     <= 1'b0;
      rd_valid <= 1'b0;
      tmr      <= step ? 16'h0000 : tmr + 16'h0001;
      unique case (state)
        M_IDLE: begin
          if (cmd_valid) begin
            state   <= M_WAIT;
            busy    <= 1'b1;
            nack    <= 1'b0;
            rd_mode <= cmd_read;
            tx      <= {cmd_addr, cmd_read};
            left    <= (cmd_len == 4'h0) ? 4'h1 : cmd_len;
            idle_cnt <= 16'h0000;
          end
        end
        M_WAIT: begin
          // START only after the bus has been free long enough
          idle_cnt <= bus_idle ? idle_cnt + 16'h0001 : 16'h0000;
          tmr      <= 16'h0000;
          if (idle_cnt == 16'(FREE)) begin
            state <= M_START;
          end
        end
        M_START: begin
          if (step) begin
            state   <= M_BIT;
            ph      <= 2'd0;
            bit_idx <= 4'h0;
            first   <= 1'b1;
          end
        end
        M_BIT: begin
          if (step) begin
            ph <= ph + 2'd1;
            if (ph == 2'd3) begin
              bit_idx <= in_ack ? 4'h0 : bit_idx + 4'h1;
              if (!in_ack) begin
                rx <= {rx[6:0], sda_sync[1]};
              end else begin
                first <= 1'b0;
                tx    <= cmd_wdata;
                if (!first) begin
                  left <= left - 4'h1;
                end
                if (reading) begin
                  rd_valid <= 1'b1;
                  rd_data  <= rx;
                end
                if ((~reading & ~ack_seen) | (~first & last)) begin
                  state <= M_STOP;
                  nack  <= ~reading & ~ack_seen;
                end
              end
            end
          end
        end
        M_STOP: begin
          if (step) begin
            ph <= ph + 2'd1;
            if (ph == 2'd3) begin
              state <= M_IDLE;
              busy  <= 1'b0;
              done  <= 1'b1;
            end
          end
        end
        // Unused state codes fall back to idle
        default: begin
          state <= M_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // Pin drive registers
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      scl_oe <= next_scl_oe;
      sda_oe <= next_sda_oe;
    end
  end

  assign link.m_scl_o  = 1'b0;
  assign link.m_scl_oe = scl_oe;
  assign link.m_sda_o  = 1'b0;
  assign link.m_sda_oe = sda_oe;

endmodule : i2csw_master

//--- i2csw_assertions.sv
`timescale 1ns/1ns
// ****************************************
// Checks on the upstream link
// ****************************************
module i2csw_assertions
  import i2csw_pkg::*;
(
  input  wire logic                link_clk,   // Slave sampling clock
  input  wire logic                rst,        // Synchronous reset
  input  wire logic                reset_n,    // Reset pin, active low
  input  wire logic                supply_ok,  // Supply above threshold
  input  wire logic [2:0]          addr_sel,   // Address straps
  input  wire logic [CHAN_CNT-1:0] channel_en, // Active channels
  input  wire logic                d_sda_oe,   // Slave pulls data
  input  wire logic                scl,        // Resolved clock line
  input  wire logic                sda         // Resolved data line
);
  logic       scl_q, sda_q, in_frame, dat, rd, hit, wv;
  logic [3:0] bitc;
  logic [7:0] sh, wb;

  // Raw line events; no filter needed, the master holds each level a quarter bit
  wire start_w = scl & scl_q & sda_q & ~sda;
  wire stop_w  = scl & scl_q & ~sda_q & sda;
  wire rise_w  = scl & ~scl_q;
  wire slot_w  = rise_w & (bitc == 4'h8);
  wire match_w = (sh[7:1] == {ADDR_HI, addr_sel});

  // Bit position and shifted bits of the current byte
  always_ff @(posedge link_clk) begin
    scl_q <= scl;
    sda_q <= sda;
    if (rst || start_w) begin
      bitc <= 4'h0;
      dat  <= 1'b0;
    end else if (slot_w) begin
      bitc <= 4'h0;
      dat  <= 1'b1;
    end else if (rise_w) begin
      bitc <= bitc + 4'h1;
      sh   <= {sh[6:0], sda};
    end
  end

  // Frame state, address outcome and last byte written
  always_ff @(posedge link_clk) begin
    in_frame <= !(rst || stop_w) && (in_frame || start_w);
    if (slot_w && !dat) begin
      rd  <= sh[0];
      hit <= match_w;
    end
    if (rst || start_w) begin
      wv <= 1'b0;
    end else if (slot_w && dat && hit && !rd) begin
      wv <= 1'b1;
      wb <= sh;
    end
  end

  default clocking cb @(posedge link_clk);
  endclocking
  default disable iff (rst);

  // Pin low long enough to pass synchronisers and the least pulse
  sequence s_pin_low;
    !reset_n [*8];
  endsequence

  // Reset and address handling
  a_pin_reset: assert property (s_pin_low |=> channel_en == 4'h0 && !d_sda_oe)
    else $error("reset pin did not clear the slave");
  a_power_hold: assert property (!supply_ok [*5] |=> channel_en == 4'h0 && !d_sda_oe)
    else $error("low supply did not hold the slave in reset");
  a_addr_ack: assert property (slot_w && !dat |-> sda == !match_w)
    else $error("address acknowledge wrong");
  // Line discipline of the slave
  a_sda_scl_low: assert property (!$past(rst) && $changed(d_sda_oe) |-> !scl)
    else $error("slave moved data while clock high");
  a_pull_in_frame: assert property (d_sda_oe |-> in_frame)
    else $error("slave pulled data outside a frame");
  a_write_ack: assert property (slot_w && dat && hit && !rd |-> !sda)
    else $error("written byte not acknowledged");
  a_read_release: assert property (slot_w && dat && hit && rd |-> !d_sda_oe)
    else $error("slave held data in read acknowledge slot");
  a_read_bits: assert property (rise_w && dat && hit && rd && bitc[3:2] == 2'h1
    |-> sda == channel_en[2'(4'h7 - bitc)])
    else $error("read bit differs from active channels");
  // Selection applies only once a STOP is seen
  a_stop_apply: assert property (stop_w && wv |-> ##[2:16] channel_en == wb[3:0])
    else $error("written selection not applied after stop");
  a_chan_at_idle: assert property ($changed(channel_en) && channel_en != 4'h0 |-> scl && sda)
    else $error("selection changed while bus busy");
endmodule : i2csw_assertions

//--- tb_i2c_switch_slave_reset_ctrl.sv
`timescale 1ns/1ns
// ****************************************
// Master and switch slave on one link
// ****************************************
module tb_i2c_switch_slave_reset_ctrl import i2csw_pkg::*;;
  logic                clk, link_clk, rst, reset_n, supply_ok;
  logic                cmd_valid, cmd_read, busy, done, nack, rd_valid;
  logic [2:0]          addr_sel;
  logic [ADDR_W-1:0]   cmd_addr;
  logic [3:0]          cmd_len;
  logic [CHAN_CNT-1:0] channel_en;
  logic [7:0]          cmd_wdata, rd_data;
  int                  bad_count, cmp_count, rd_cnt;
  logic [7:0]          vals [6] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'hF3, 8'h00};

  i2csw_link_if link_if ();

  // Slave on the link clock, master on the system clock
  i2csw_dev i2csw_dev_inst (
    .link_clk(link_clk), .rst(rst), .reset_n(reset_n), .supply_ok(supply_ok),
    .addr_sel(addr_sel), .link(link_if.dev), .channel_en(channel_en));
  // Shortest quarter bit that the slave filter still follows
  i2csw_master #(.QTR(24)) i2csw_master_inst (
    .clk(clk), .rst(rst), .link(link_if.master), .cmd_valid(cmd_valid),
    .cmd_read(cmd_read), .cmd_addr(cmd_addr), .cmd_len(cmd_len),
    .cmd_wdata(cmd_wdata), .busy(busy), .done(done), .nack(nack),
    .rd_valid(rd_valid), .rd_data(rd_data));
  i2csw_assertions i2csw_assertions_inst (
    .link_clk(link_clk), .rst(rst), .reset_n(reset_n), .supply_ok(supply_ok),
    .addr_sel(addr_sel), .channel_en(channel_en), .d_sda_oe(link_if.d_sda_oe),
    .scl(link_if.scl), .sda(link_if.sda));

  // Link clock starts offset so its edges never meet the system clock
  always #20 clk = ~clk;
  initial begin
    link_clk = 1'b0;
    #7;
    forever #80 link_clk = ~link_clk;
  end

  task automatic end_sim;
    $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_sim

  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  // One master command; entered and left on a falling edge
  task automatic xfer(input logic rd, input logic [ADDR_W-1:0] addr, input logic [3:0] len,
                      input logic [7:0] wd);
    int n;
    cmd_read  = rd;
    cmd_addr  = addr;
    cmd_len   = len;
    cmd_wdata = wd;
    cmd_valid = 1'b1;
    @(negedge clk);
    cmd_valid = 1'b0;
    n = 0;
    rd_cnt = 0;
    while (done !== 1'b1 && n < 20000) begin
      @(negedge clk);
      n++;
      if (rd_valid === 1'b1) begin
        rd_cnt++;
      end
    end
    if (n >= 20000) begin
      bad_count++;
      $display("CHECK FAILED done expected 1 seen 0");
      end_sim();
    end
    check("bus_idle", 8'h03, {5'h00, busy, link_if.scl, link_if.sda});
  endtask : xfer

  // Two-byte read, so the last byte goes unacknowledged
  task automatic readback(input logic [7:0] exp);
    xfer(1'b1, {ADDR_HI, addr_sel}, 4'h2, 8'h00);
    check("rd_data", exp, rd_data);
    check("rd_cnt", 8'h02, 8'(rd_cnt));
    check("chan_en", {4'h0, exp[3:0]}, {4'h0, channel_en});
  endtask : readback

  initial begin
    clk       = 1'b0;
    rst       = 1'b1;
    reset_n   = 1'b1;
    supply_ok = 1'b0;
    addr_sel  = 3'h5;
    cmd_valid = 1'b0;
    cmd_read  = 1'b0;
    cmd_addr  = 7'h00;
    cmd_len   = 4'h0;
    cmd_wdata = 8'h00;
    bad_count = 0;
    cmp_count = 0;
    repeat (6) @(negedge clk);
    rst = 1'b0;
    // Supply still low: slave held in reset, lines idle
    repeat (8) @(negedge clk);
    check("scl_idle", 8'h01, {7'h00, link_if.scl});
    check("sda_idle", 8'h01, {7'h00, link_if.sda});
    check("chan_por", 8'h00, {4'h0, channel_en});
    supply_ok = 1'b1;
    // Each single channel, a mix with high bits set, then none
    foreach (vals[i]) begin
      xfer(1'b0, {ADDR_HI, addr_sel}, 4'h0, vals[i]);
      check("wr_nack", 8'h00, {7'h00, nack});
      readback(vals[i]);
    end
    // Long write: every byte taken, last one kept
    xfer(1'b0, {ADDR_HI, addr_sel}, 4'h8, 8'h09);
    check("wr_nack", 8'h00, {7'h00, nack});
    readback(8'h09);
    // Wrong low bits then wrong high bits, as write and as read
    for (int k = 0; k < 4; k++) begin
      xfer(k[0], k[1] ? {4'h6, addr_sel} : {ADDR_HI, ~addr_sel}, 4'h0, 8'h0F);
      check("bad_nack", 8'h01, {7'h00, nack});
      check("bad_rd", 8'h00, 8'(rd_cnt));
    end
    readback(8'h09);
    // Reset pin held past the least pulse, checked while still low
    reset_n = 1'b0;
    repeat ((RST_PULSE_CYC + 8) * 4) @(negedge clk);
    check("chan_pin", 8'h00, {4'h0, channel_en});
    reset_n = 1'b1;
    readback(8'h00);
    // Supply dip acts as power-on reset
    xfer(1'b0, {ADDR_HI, addr_sel}, 4'h0, 8'h06);
    readback(8'h06);
    supply_ok = 1'b0;
    repeat (48) @(negedge clk);
    check("chan_sup", 8'h00, {4'h0, channel_en});
    supply_ok = 1'b1;
    readback(8'h00);
    end_sim();
  end
endmodule : tb_i2c_switch_slave_reset_ctrl
